// ---- pkg/crc16_pkg.sv ----
// Constants and state type for the byte-serial CRC-16 generator
package crc16_pkg;

  // Register write selects
  localparam logic [1:0] SEL_CONTROL    = 2'h0;
  localparam logic [1:0] SEL_INPUT_BYTE = 2'h1;
  localparam logic [1:0] SEL_CHECK_LOW  = 2'h2;
  localparam logic [1:0] SEL_CHECK_HIGH = 2'h3;

  // Control register layout
  localparam int         POLYNOMIAL_SELECT_SEL_BIT   = 0;
  localparam logic [7:0] CONTROL_MASK   = 8'h01;

  // Polynomial select encodings and their feedback constants
  localparam logic       POLYNOMIAL_SELECT_CCITT     = 1'b0;
  localparam logic       POLYNOMIAL_SELECT_CRC16     = 1'b1;
  localparam logic [15:0] CCITT_CONST   = 16'h1021;
  localparam logic [15:0] CRC16_CONST   = 16'h8005;

  // Bits folded per written byte
  localparam int         BYTE_BITS      = 8;

  // Power-on values
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam logic       POLYNOMIAL_SELECT_RESET     = 1'b0;

  typedef struct packed {
    logic        polynomial_select;
    logic [7:0]  crc_input_byte;
    logic [7:0]  checksum_high_byte;
    logic [7:0]  checksum_low_byte;
  } crc_state_type;

endpackage

// ---- verilog/byte_crc16_generator.sv ----
// Byte-serial CRC generator with selectable CCITT or CRC-16 polynomial
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each input byte write starts a checksum update
// - Update completes in one cycle, readable next
// - Temp high byte is input xor checksum high
// - Each bit step shifts left, zero enters
// - Shifted-out one applies polynomial xor
// - Constant 8005H for CRC-16, 1021H CCITT
// - Eight bit steps per written byte
// - Result stored back, successive bytes chain
// - Zero start, byte 01H gives reference values
// - Bytes 78h,56h,34h,12h reproduce listed checksums
// - Select bit 0, reset zero, upper bits zero
// - Three byte registers read/write, reset zero
module byte_crc16_generator (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register write port
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sel,
  input  wire logic [7:0] wr_data,
  // Register read values
  output logic      [7:0] crc_control,
  output logic      [7:0] crc_input_byte,
  output logic      [7:0] checksum_high_byte,
  output logic      [7:0] checksum_low_byte
);

  crc16_pkg::crc_state_type state;
  crc16_pkg::crc_state_type next_state;

  // Whole byte folded combinationally so the result lands on the write edge;
  // eight chained stages cost depth but keep the update to a single cycle
  logic [15:0]                            feedback;
  logic [crc16_pkg::BYTE_BITS:0][15:0]    stage;

  assign feedback = (state.polynomial_select == crc16_pkg::POLYNOMIAL_SELECT_CRC16)
                  ? crc16_pkg::CRC16_CONST : crc16_pkg::CCITT_CONST;
  assign stage[0] = {state.checksum_high_byte ^ wr_data, state.checksum_low_byte};

  for (genvar i = 0; i < crc16_pkg::BYTE_BITS; i++) begin : g_bit_step
    logic [15:0] shifted;
    assign shifted      = {stage[i][14:0], 1'b0};
    assign stage[i + 1] = stage[i][15] ? (shifted ^ feedback) : shifted;
  end

  logic [15:0] folded;

  always_comb begin
    next_state = state;
    folded     = stage[crc16_pkg::BYTE_BITS];
    if (wr_en) begin
      case (wr_sel)
        crc16_pkg::SEL_CONTROL: begin
          next_state.polynomial_select = wr_data[crc16_pkg::POLYNOMIAL_SELECT_SEL_BIT];
        end
        crc16_pkg::SEL_INPUT_BYTE: begin
          // Uses the polynomial already held; a select written in the same
          // cycle cannot occur because the port carries one write per cycle
          next_state.crc_input_byte     = wr_data;
          next_state.checksum_high_byte = folded[15:8];
          next_state.checksum_low_byte  = folded[7:0];
        end
        crc16_pkg::SEL_CHECK_LOW: begin
          next_state.checksum_low_byte  = wr_data;
        end
        crc16_pkg::SEL_CHECK_HIGH: begin
          next_state.checksum_high_byte = wr_data;
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state.polynomial_select  <= crc16_pkg::POLYNOMIAL_SELECT_RESET;
      state.crc_input_byte     <= crc16_pkg::BYTE_RESET;
      state.checksum_high_byte <= crc16_pkg::BYTE_RESET;
      state.checksum_low_byte  <= crc16_pkg::BYTE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign crc_control        = {7'h00, state.polynomial_select} & crc16_pkg::CONTROL_MASK;
  assign crc_input_byte     = state.crc_input_byte;
  assign checksum_high_byte = state.checksum_high_byte;
  assign checksum_low_byte  = state.checksum_low_byte;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [15:0] sum;
  logic        in_wr;
  assign sum   = {checksum_high_byte, checksum_low_byte};
  assign in_wr = wr_en && (wr_sel == crc16_pkg::SEL_INPUT_BYTE);

  chk_ccitt_one_byte: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h01
      |=> sum == 16'h1021)
    else $error("CCITT result for 01H wrong");

  chk_crc16_one_byte: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h01
      |=> sum == 16'h8005)
    else $error("CRC-16 result for 01H wrong");

  chk_bit_steps: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h07
      |=> sum == 16'h8011)
    else $error("CRC-16 result for 07H wrong");

  chk_high_xor_cancel: assert property (
    in_wr && checksum_low_byte == 8'h00 && wr_data == checksum_high_byte
      |=> sum == 16'h0000)
    else $error("Input not combined with checksum high byte");

  chk_chain_ccitt: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h78
      ##1 in_wr && wr_data == 8'h56 && !crc_control[0]
      |=> sum == 16'hBBC3)
    else $error("CCITT chain result wrong");

  chk_chain_crc16: assert property (
    in_wr && sum == 16'h0110 && crc_control[0] && wr_data == 8'h56
      |=> sum == 16'h91F1)
    else $error("CRC-16 chain result wrong");

  chk_sum_holds: assert property (
    !wr_en |=> $stable(sum))
    else $error("Checksum changed without a write");

  chk_seed_load: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CHECK_HIGH
      |=> checksum_high_byte == $past(wr_data) && $stable(checksum_low_byte))
    else $error("Seed write did not load directly");

  chk_control_upper: assert property (
    crc_control[7:1] == 7'h00)
    else $error("Control upper bits not zero");

  chk_input_capture: assert property (
    in_wr |=> crc_input_byte == $past(wr_data))
    else $error("Input byte register not loaded");

  // Single bytes from a zero checksum
  chk_ccitt_byte_00: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h00
      |=> sum == 16'h0000)
    else $error("CCITT result for 00H wrong");

  chk_ccitt_byte_02: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h02
      |=> sum == 16'h2042)
    else $error("CCITT result for 02H wrong");

  chk_ccitt_byte_03: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h03
      |=> sum == 16'h3063)
    else $error("CCITT result for 03H wrong");

  chk_ccitt_byte_04: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h04
      |=> sum == 16'h4084)
    else $error("CCITT result for 04H wrong");

  chk_ccitt_byte_05: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h05
      |=> sum == 16'h50A5)
    else $error("CCITT result for 05H wrong");

  chk_ccitt_byte_06: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h06
      |=> sum == 16'h60C6)
    else $error("CCITT result for 06H wrong");

  chk_ccitt_byte_07: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h07
      |=> sum == 16'h70E7)
    else $error("CCITT result for 07H wrong");

  chk_crc16_byte_00: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h00
      |=> sum == 16'h0000)
    else $error("CRC-16 result for 00H wrong");

  chk_crc16_byte_02: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h02
      |=> sum == 16'h800F)
    else $error("CRC-16 result for 02H wrong");

  chk_crc16_byte_03: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h03
      |=> sum == 16'h000A)
    else $error("CRC-16 result for 03H wrong");

  chk_crc16_byte_04: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h04
      |=> sum == 16'h801B)
    else $error("CRC-16 result for 04H wrong");

  chk_crc16_byte_05: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h05
      |=> sum == 16'h001E)
    else $error("CRC-16 result for 05H wrong");

  chk_crc16_byte_06: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h06
      |=> sum == 16'h0014)
    else $error("CRC-16 result for 06H wrong");

  // Each step of the four-byte chain but CRC-16 56h (chk_chain_crc16), from whatever path reached it
  chk_ccitt_step_78: assert property (
    in_wr && sum == 16'h0000 && !crc_control[0] && wr_data == 8'h78
      |=> sum == 16'hFF9F)
    else $error("CCITT step for 78h wrong");

  chk_ccitt_step_56: assert property (
    in_wr && sum == 16'hFF9F && !crc_control[0] && wr_data == 8'h56
      |=> sum == 16'hBBC3)
    else $error("CCITT step for 56h wrong");

  chk_ccitt_step_34: assert property (
    in_wr && sum == 16'hBBC3 && !crc_control[0] && wr_data == 8'h34
      |=> sum == 16'hA367)
    else $error("CCITT step for 34h wrong");

  chk_ccitt_step_12: assert property (
    in_wr && sum == 16'hA367 && !crc_control[0] && wr_data == 8'h12
      |=> sum == 16'hD0FA)
    else $error("CCITT step for 12h wrong");

  chk_crc16_step_78: assert property (
    in_wr && sum == 16'h0000 && crc_control[0] && wr_data == 8'h78
      |=> sum == 16'h0110)
    else $error("CRC-16 step for 78h wrong");

  chk_crc16_step_34: assert property (
    in_wr && sum == 16'h91F1 && crc_control[0] && wr_data == 8'h34
      |=> sum == 16'hF2DE)
    else $error("CRC-16 step for 34h wrong");

  chk_crc16_step_12: assert property (
    in_wr && sum == 16'hF2DE && crc_control[0] && wr_data == 8'h12
      |=> sum == 16'h5C43)
    else $error("CRC-16 step for 12h wrong");

  // Register writes that must not start a computation
  chk_seed_low: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CHECK_LOW
      |=> checksum_low_byte == $past(wr_data) && $stable(checksum_high_byte))
    else $error("Low seed write did not load directly");

  chk_seed_keeps_input: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CHECK_HIGH
      |=> $stable(crc_input_byte))
    else $error("High seed write changed input byte");

  chk_low_keeps_input: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CHECK_LOW
      |=> $stable(crc_input_byte))
    else $error("Low seed write changed input byte");

  chk_control_write: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CONTROL
      |=> crc_control[0] == $past(wr_data[0]))
    else $error("Polynomial select not loaded");

  chk_control_no_fold: assert property (
    wr_en && wr_sel == crc16_pkg::SEL_CONTROL
      |=> $stable(sum))
    else $error("Control write changed checksum");

  chk_polynomial_select_holds: assert property (
    !(wr_en && wr_sel == crc16_pkg::SEL_CONTROL)
      |=> $stable(crc_control))
    else $error("Polynomial select changed without a write");

  chk_input_holds: assert property (
    !in_wr |=> $stable(crc_input_byte))
    else $error("Input byte changed without a write");

  cov_ccitt_byte: cover property (in_wr && !crc_control[0]);
  cov_control_then_data: cover property (
    wr_en && wr_sel == crc16_pkg::SEL_CONTROL ##1 in_wr);
  cov_crc16_byte: cover property (in_wr && crc_control[0]);
  cov_back_to_back: cover property (in_wr ##1 in_wr);
  cov_seed_then_data: cover property (
    wr_en && wr_sel == crc16_pkg::SEL_CHECK_LOW ##1 in_wr);

endmodule // byte_crc16_generator

`default_nettype wire

// ---- verif/test_byte_crc16_generator.sv ----
// Self-checking bench for the byte-serial CRC generator
`timescale 1ns/1ps
`default_nettype none
module test_byte_crc16_generator;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr_en = 1'b0;
  logic [1:0]  wr_sel = 2'h0;
  logic [7:0]  wr_data = 8'h00;
  logic [7:0]  ctl, inb, hi, lo;
  int          n_fail = 0;
  int          total_checks = 0;
  logic [15:0] one_ref [2][8] = '{
    '{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50A5, 16'h60C6, 16'h70E7},
    '{16'h0000, 16'h8005, 16'h800F, 16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
  logic [15:0] seq_ref [2][4] = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
    '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
  logic [7:0]  seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};

  byte_crc16_generator dut (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .crc_control(ctl), .crc_input_byte(inb),
    .checksum_high_byte(hi), .checksum_low_byte(lo));

  always #2.5 clk = ~clk;

  task automatic close_out;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe stays up across calls, so back-to-back writes need no idle cycle
  task automatic step(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
  endtask

  task automatic stop;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // Upper control bits carry junk on purpose: they must not stick
  task automatic start(input int p);
    step(crc16_pkg::SEL_CHECK_HIGH, 8'h00);
    step(crc16_pkg::SEL_CHECK_LOW, 8'h00);
    step(crc16_pkg::SEL_CONTROL, p ? 8'hFF : 8'hFE);
    stop;
    cmp({8'h00, ctl}, p ? 16'h0001 : 16'h0000);
    cmp({hi, lo}, 16'h0000);
  endtask

  task automatic reset_values;
    cmp({ctl, inb}, 16'h0000);
    cmp({hi, lo}, 16'h0000);
  endtask

  task automatic single_bytes;
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 8; b++) begin
        start(p);
        step(crc16_pkg::SEL_INPUT_BYTE, 8'(b));
        stop;
        cmp({8'h00, inb}, 16'(b));
        cmp({hi, lo}, one_ref[p][b]);
      end
    end
  endtask

  // Each result but the last is read while the next byte is already on the bus
  task automatic chain;
    for (int p = 0; p < 2; p++) begin
      start(p);
      for (int i = 0; i < 4; i++) begin
        step(crc16_pkg::SEL_INPUT_BYTE, seq_in[i]);
        if (i > 0) cmp({hi, lo}, seq_ref[p][i-1]);
      end
      stop;
      cmp({hi, lo}, seq_ref[p][3]);
    end
  endtask

  task automatic seed_and_reset;
    start(0);
    step(crc16_pkg::SEL_CHECK_HIGH, 8'hFF);
    step(crc16_pkg::SEL_CHECK_LOW, 8'h9F);
    stop;
    cmp({hi, lo}, 16'hFF9F);
    cmp({8'h00, inb}, 16'h0012);
    step(crc16_pkg::SEL_INPUT_BYTE, 8'h56);
    stop;
    cmp({hi, lo}, 16'hBBC3);
    sys_rst = 1'b1;
    @(negedge clk);
    reset_values();
    sys_rst = 1'b0;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    reset_values();
    single_bytes();
    chain();
    seed_and_reset();
    close_out();
  end

  // The sequence needs about 130 cycles; 2000 leaves ample margin
  initial begin
    #10000;
    n_fail++;
    close_out();
  end
endmodule // test_byte_crc16_generator
`default_nettype wire
